// ### logic/axis_pkg.sv
// Shared constants for the plasma axis select drivers.
// Assumes a single 10 MHz system clock domain.
package axis_pkg;
    localparam int unsigned OUT_COUNT = 32;
    localparam int unsigned GROUP_WIDTH = 8;
    localparam int unsigned GROUP_COUNT = 4;
    localparam logic [1:0] SEL_GROUP_ONE = 2'h0;
    localparam logic [1:0] SEL_GROUP_TWO = 2'h1;
    localparam logic [1:0] SEL_GROUP_THREE = 2'h2;
    localparam logic [1:0] SEL_GROUP_FOUR = 2'h3;
    localparam logic [7:0] POS_SHIFT_RESET = 8'hFF;
    localparam logic [31:0] NEG_SHIFT_RESET = 32'hFFFFFFFF;
    localparam logic [31:0] POS_IDLE = 32'h00000000;
    localparam logic [31:0] NEG_IDLE = 32'hFFFFFFFF;
endpackage : axis_pkg

// ### logic/select_buffer.sv
// Two-entry valid/ready buffer for serial select bits.
// Assumes source and sink on the same clock.
`timescale 1ns/100ps
`default_nettype none
module select_buffer #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // Drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    logic [WIDTH-1:0] mem_ff [2];
    logic [WIDTH-1:0] nxt_mem [2];
    logic rd_ptr_ff;
    logic nxt_rd_ptr;
    logic wr_ptr_ff;
    logic nxt_wr_ptr;
    logic [1:0] count_ff;
    logic [1:0] nxt_count;
    logic push;
    logic pop;

    if (WIDTH < 1) begin : g_width_check
        $error("select_buffer width must be at least one");
    end

    assign o_ready = (count_ff != 2'h2);
    assign o_valid = (count_ff != 2'h0);
    assign o_data = mem_ff[rd_ptr_ff];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_comb begin
        nxt_mem = mem_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_count = count_ff;
        if (push) begin
            nxt_mem[wr_ptr_ff] = i_data;
            nxt_wr_ptr = ~wr_ptr_ff;
        end
        if (pop) begin
            nxt_rd_ptr = ~rd_ptr_ff;
        end
        if (push && !pop) begin
            nxt_count = count_ff + 2'h1;
        end else if (pop && !push) begin
            nxt_count = count_ff - 2'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else begin
            mem_ff <= nxt_mem;
            rd_ptr_ff <= nxt_rd_ptr;
            wr_ptr_ff <= nxt_wr_ptr;
            count_ff <= nxt_count;
        end
    end

    property p_no_overflow;
        @(posedge i_clk) disable iff (!i_rstn)
        (count_ff == 2'h2 && !pop) |=> (count_ff == 2'h2);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("full buffer changed");
endmodule : select_buffer
`default_nettype wire

// ### logic/plasma_axis_select_driver.sv
// Select logic of a positive-pulse and a negative-pulse plasma axis driver.
// Assumes the controller pins are asynchronous to i_sys_clk.
`timescale 1ns/100ps
`default_nettype none

module plasma_axis_select_driver (
    // System
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Positive-pulse driver pins
    input wire logic i_pos_data,
    input wire logic i_pos_shift_clk,
    input wire logic i_pos_strobe_n,
    input wire logic i_group_select_low_bit,
    input wire logic i_group_select_high_bit,
    // Negative-pulse driver pins
    input wire logic i_neg_data,
    input wire logic i_neg_shift_clk,
    input wire logic i_neg_strobe_n,
    input wire logic i_neg_sustain_n,
    // Positive outputs by group
    output logic [axis_pkg::GROUP_WIDTH-1:0] o_group_one_outputs,
    output logic [axis_pkg::GROUP_WIDTH-1:0] o_group_two_outputs,
    output logic [axis_pkg::GROUP_WIDTH-1:0] o_group_three_outputs,
    output logic [axis_pkg::GROUP_WIDTH-1:0] o_group_four_outputs,
    // Negative outputs
    output logic [axis_pkg::OUT_COUNT-1:0] o_neg_outputs
);
    import axis_pkg::*;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire rstn = rst_sync_ff;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    localparam int unsigned PIN_COUNT = 9;
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_meta_ff;
    logic [PIN_COUNT-1:0] pin_sync_ff;
    logic [PIN_COUNT-1:0] pin_prev_ff;
    assign pin_raw = {i_pos_data, i_pos_shift_clk, i_pos_strobe_n,
                      i_group_select_low_bit, i_group_select_high_bit,
                      i_neg_data, i_neg_shift_clk, i_neg_strobe_n, i_neg_sustain_n};

    always_ff @(posedge i_sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_ff <= {PIN_COUNT{1'b1}};
            pin_sync_ff <= {PIN_COUNT{1'b1}};
            pin_prev_ff <= {PIN_COUNT{1'b1}};
        end else begin
            pin_meta_ff <= pin_raw;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    logic pos_data_s;
    logic pos_strobe_n_s;
    logic sel_low_s;
    logic sel_high_s;
    logic neg_data_s;
    logic neg_strobe_n_s;
    logic neg_sustain_n_s;
    logic pos_clk_rise;
    logic neg_clk_rise;
    assign pos_data_s = pin_sync_ff[8];
    assign pos_strobe_n_s = pin_sync_ff[6];
    assign sel_low_s = pin_sync_ff[5];
    assign sel_high_s = pin_sync_ff[4];
    assign neg_data_s = pin_sync_ff[3];
    assign neg_strobe_n_s = pin_sync_ff[1];
    assign neg_sustain_n_s = pin_sync_ff[0];
    assign pos_clk_rise = pin_sync_ff[7] && !pin_prev_ff[7];
    assign neg_clk_rise = pin_sync_ff[2] && !pin_prev_ff[2];

    // ----------------------------------------
    // Positive data buffer
    // ----------------------------------------
    logic pos_buf_ready;
    logic pos_buf_valid;
    logic pos_buf_data;
    logic pos_shift_take;
    // Loading stalls while strobing so the store is not disturbed
    assign pos_shift_take = pos_strobe_n_s;

    select_buffer #(
        .WIDTH(1)
    ) u_pos_buffer (
        .i_clk(i_sys_clk),
        .i_rstn(rstn),
        .i_valid(pos_clk_rise),
        .i_data(pos_data_s),
        .o_ready(pos_buf_ready),
        .o_valid(pos_buf_valid),
        .o_data(pos_buf_data),
        .i_ready(pos_shift_take)
    );

    // ----------------------------------------
    // Shift registers
    // ----------------------------------------
    logic [GROUP_WIDTH-1:0] pos_shift_ff;
    logic [GROUP_WIDTH-1:0] nxt_pos_shift;
    logic [OUT_COUNT-1:0] neg_shift_ff;
    logic [OUT_COUNT-1:0] nxt_neg_shift;

    always_comb begin
        nxt_pos_shift = pos_shift_ff;
        nxt_neg_shift = neg_shift_ff;
        if (pos_buf_valid && pos_shift_take) begin
            nxt_pos_shift = {pos_shift_ff[GROUP_WIDTH-2:0], pos_buf_data};
        end
        if (neg_clk_rise && neg_strobe_n_s) begin
            nxt_neg_shift = {neg_shift_ff[OUT_COUNT-2:0], neg_data_s};
        end
    end

    always_ff @(posedge i_sys_clk or negedge rstn) begin
        if (!rstn) begin
            pos_shift_ff <= POS_SHIFT_RESET;
            neg_shift_ff <= NEG_SHIFT_RESET;
        end else begin
            pos_shift_ff <= nxt_pos_shift;
            neg_shift_ff <= nxt_neg_shift;
        end
    end

    // ----------------------------------------
    // Group decode
    // ----------------------------------------
    function automatic logic [GROUP_COUNT-1:0] group_decode(input logic lo, input logic hi);
        case ({hi, lo})
            SEL_GROUP_ONE: group_decode = 4'h1;
            SEL_GROUP_TWO: group_decode = 4'h2;
            SEL_GROUP_THREE: group_decode = 4'h4;
            default: group_decode = 4'h8;
        endcase
    endfunction : group_decode

    logic [GROUP_COUNT-1:0] group_en;
    assign group_en = group_decode(sel_low_s, sel_high_s);

    // ----------------------------------------
    // Output drive
    // ----------------------------------------
    logic [OUT_COUNT-1:0] pos_out_ff;
    logic [OUT_COUNT-1:0] nxt_pos_out;
    logic [OUT_COUNT-1:0] neg_out_ff;
    logic [OUT_COUNT-1:0] nxt_neg_out;

    genvar g;
    generate
        for (g = 0; g < GROUP_COUNT; g++) begin : g_pos_group
            always_comb begin
                // active group only, zero bit selects
                if (!pos_strobe_n_s && group_en[g]) begin
                    nxt_pos_out[g*GROUP_WIDTH +: GROUP_WIDTH] = ~pos_shift_ff;
                end else begin
                    nxt_pos_out[g*GROUP_WIDTH +: GROUP_WIDTH] = POS_IDLE[GROUP_WIDTH-1:0];
                end
            end
        end
    endgenerate

    always_comb begin
        if (!neg_sustain_n_s) begin
            nxt_neg_out = '0;
        end else if (!neg_strobe_n_s) begin
            nxt_neg_out = neg_shift_ff;
        end else begin
            nxt_neg_out = NEG_IDLE;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rstn) begin
        if (!rstn) begin
            pos_out_ff <= POS_IDLE;
            neg_out_ff <= NEG_IDLE;
        end else begin
            pos_out_ff <= nxt_pos_out;
            neg_out_ff <= nxt_neg_out;
        end
    end

    assign o_group_one_outputs = pos_out_ff[7:0];
    assign o_group_two_outputs = pos_out_ff[15:8];
    assign o_group_three_outputs = pos_out_ff[23:16];
    assign o_group_four_outputs = pos_out_ff[31:24];
    assign o_neg_outputs = neg_out_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_pos_idle;
        @(posedge i_sys_clk) disable iff (!rstn)
        pos_strobe_n_s |=> (pos_out_ff == POS_IDLE);
    endproperty
    a_pos_idle: assert property (p_pos_idle) else $error("positive outputs not idle");

    property p_one_group;
        @(posedge i_sys_clk) disable iff (!rstn)
        ##1 $countones({|pos_out_ff[31:24], |pos_out_ff[23:16],
                        |pos_out_ff[15:8], |pos_out_ff[7:0]}) <= 1;
    endproperty
    a_one_group: assert property (p_one_group) else $error("two groups active");

    property p_group_data;
        @(posedge i_sys_clk) disable iff (!rstn)
        (!pos_strobe_n_s && !sel_low_s && !sel_high_s)
            |=> (o_group_one_outputs == ~$past(pos_shift_ff));
    endproperty
    a_group_data: assert property (p_group_data) else $error("group one data wrong");

    property p_group_four;
        @(posedge i_sys_clk) disable iff (!rstn)
        (!pos_strobe_n_s && sel_low_s && sel_high_s)
            |=> (pos_out_ff[23:0] == 24'h000000);
    endproperty
    a_group_four: assert property (p_group_four) else $error("group four decode wrong");

    property p_shift_in;
        @(posedge i_sys_clk) disable iff (!rstn)
        (neg_clk_rise && neg_strobe_n_s)
            |=> (neg_shift_ff[0] == $past(neg_data_s));
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("negative shift missed");

    property p_sustain;
        @(posedge i_sys_clk) disable iff (!rstn)
        !neg_sustain_n_s |=> (o_neg_outputs == 32'h00000000);
    endproperty
    a_sustain: assert property (p_sustain) else $error("sustain did not force low");

    property p_neg_strobe;
        @(posedge i_sys_clk) disable iff (!rstn)
        (neg_sustain_n_s && !neg_strobe_n_s) |=> (o_neg_outputs == $past(neg_shift_ff));
    endproperty
    a_neg_strobe: assert property (p_neg_strobe) else $error("negative strobe data wrong");

    property p_hold;
        @(posedge i_sys_clk) disable iff (!rstn)
        (!pos_strobe_n_s ##1 !pos_strobe_n_s) |-> $stable(pos_shift_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("store changed during strobe");

    property p_pos_shift;
        @(posedge i_sys_clk) disable iff (!rstn)
        (pos_buf_valid && pos_shift_take)
            |=> (pos_shift_ff[0] == $past(pos_buf_data));
    endproperty
    a_pos_shift: assert property (p_pos_shift) else $error("positive shift missed");

    property p_buf_full;
        @(posedge i_sys_clk) disable iff (!rstn)
        !pos_buf_ready |-> ($past(pos_strobe_n_s) == 1'b0);
    endproperty
    a_buf_full: assert property (p_buf_full) else $error("buffer filled while draining");

    property p_neg_refuse;
        @(posedge i_sys_clk) disable iff (!rstn)
        (neg_clk_rise && !neg_strobe_n_s) |=> $stable(neg_shift_ff);
    endproperty
    a_neg_refuse: assert property (p_neg_refuse) else $error("negative shift on strobe");

    property p_neg_idle;
        @(posedge i_sys_clk) disable iff (!rstn)
        (neg_sustain_n_s && neg_strobe_n_s) |=> (o_neg_outputs == NEG_IDLE);
    endproperty
    a_neg_idle: assert property (p_neg_idle) else $error("negative outputs not idle");
endmodule : plasma_axis_select_driver
`default_nettype wire

// ### bench/axis_ctrl_model.sv
// Display controller model driving the serial pins of both axis drivers.
// Assumes the bench calls its tasks; pins change on falling system clock edges.
`timescale 1ns/100ps
`default_nettype none
module axis_ctrl_model (
    // Clock
    input wire logic i_sys_clk,
    // Positive driver pins
    output logic o_pos_data,
    output logic o_pos_shift_clk,
    output logic o_pos_strobe_n,
    output logic o_group_select_low_bit,
    output logic o_group_select_high_bit,
    // Negative driver pins
    output logic o_neg_data,
    output logic o_neg_shift_clk,
    output logic o_neg_strobe_n,
    output logic o_neg_sustain_n
);
    initial begin
        o_pos_data = 1'b1;
        o_pos_shift_clk = 1'b0;
        o_pos_strobe_n = 1'b1;
        o_group_select_low_bit = 1'b0;
        o_group_select_high_bit = 1'b0;
        o_neg_data = 1'b1;
        o_neg_shift_clk = 1'b0;
        o_neg_strobe_n = 1'b1;
        o_neg_sustain_n = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : hold

    // one bit per rise; data inverted once released
    task automatic shift_bit(input logic pos, input logic b);
        o_pos_data = pos ? b : o_pos_data;
        o_neg_data = pos ? o_neg_data : b;
        hold(4);
        o_pos_shift_clk = pos;
        o_neg_shift_clk = !pos;
        hold(4);
        o_pos_shift_clk = 1'b0;
        o_neg_shift_clk = 1'b0;
        o_pos_data = pos ? !b : o_pos_data;
        o_neg_data = pos ? o_neg_data : !b;
        hold(4);
    endtask : shift_bit

    task automatic shift_pos(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            shift_bit(1'b1, d[i]);
        end
    endtask : shift_pos

    task automatic shift_neg(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            shift_bit(1'b0, w[i]);
        end
    endtask : shift_neg

    task automatic set_select(input logic [1:0] s);
        o_group_select_low_bit = s[0];
        o_group_select_high_bit = s[1];
        hold(6);
    endtask : set_select

    task automatic set_strobe(input logic pos, input logic lvl);
        o_pos_strobe_n = pos ? lvl : o_pos_strobe_n;
        o_neg_strobe_n = pos ? o_neg_strobe_n : lvl;
        hold(6);
    endtask : set_strobe

    task automatic set_sustain(input logic lvl);
        o_neg_sustain_n = lvl;
        hold(6);
    endtask : set_sustain
endmodule : axis_ctrl_model
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the plasma axis select driver pair.
// Assumes the controller model drives every pin except clock and reset.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import axis_pkg::*;
    logic i_sys_clk;
    logic i_resetn;
    wire logic pd, pc, ps, sl, sh, nd, nc, ns, nu;
    wire logic [7:0] g1, g2, g3, g4;
    wire logic [31:0] neg_out;
    wire logic [31:0] pos_all = {g4, g3, g2, g1};
    int bad_count;
    int cmp_count;

    axis_ctrl_model m (.i_sys_clk(i_sys_clk), .o_pos_data(pd), .o_pos_shift_clk(pc),
        .o_pos_strobe_n(ps), .o_group_select_low_bit(sl), .o_group_select_high_bit(sh),
        .o_neg_data(nd), .o_neg_shift_clk(nc), .o_neg_strobe_n(ns), .o_neg_sustain_n(nu));

    plasma_axis_select_driver i_dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
        .i_pos_data(pd), .i_pos_shift_clk(pc), .i_pos_strobe_n(ps),
        .i_group_select_low_bit(sl), .i_group_select_high_bit(sh), .i_neg_data(nd),
        .i_neg_shift_clk(nc), .i_neg_strobe_n(ns), .i_neg_sustain_n(nu),
        .o_group_one_outputs(g1), .o_group_two_outputs(g2), .o_group_three_outputs(g3),
        .o_group_four_outputs(g4), .o_neg_outputs(neg_out));

    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_groups();
        logic [7:0] pat [4] = '{8'hA5, 8'h7E, 8'h00, 8'hC3};
        for (int g = 0; g < 4; g++) begin
            m.shift_pos(pat[g]);
            m.set_select(g[1:0]);
            chk("pos idle", POS_IDLE, pos_all);
            m.set_strobe(1'b1, 1'b0);
            chk("pos group", {24'h000000, ~pat[g]} << (8 * g), pos_all);
            m.set_strobe(1'b1, 1'b1);
            chk("pos rest", POS_IDLE, pos_all);
        end
    endtask : t_groups

    task automatic t_buffer();
        logic [7:0] p = 8'h3C;
        logic [7:0] nxt = {p[5:0], 1'b0, 1'b1};
        m.shift_pos(p);
        m.hold(20);
        chk("pos hold", POS_IDLE, pos_all);
        m.set_strobe(1'b1, 1'b0);
        m.shift_bit(1'b1, 1'b0);
        m.shift_bit(1'b1, 1'b1);
        m.shift_bit(1'b1, 1'b0);
        chk("pos stall", {~p, 24'h000000}, pos_all);
        m.set_strobe(1'b1, 1'b1);
        m.hold(10);
        m.set_strobe(1'b1, 1'b0);
        chk("pos drain", {~nxt, 24'h000000}, pos_all);
        m.set_strobe(1'b1, 1'b1);
    endtask : t_buffer

    task automatic t_neg();
        logic [31:0] w = 32'h5A0FC381;
        m.shift_neg(w);
        chk("neg idle", NEG_IDLE, neg_out);
        m.set_strobe(1'b0, 1'b0);
        chk("neg strobe", w, neg_out);
        for (int i = 0; i < 4; i++) begin
            m.shift_bit(1'b0, 1'b0);
        end
        m.set_strobe(1'b0, 1'b1);
        chk("neg rest", NEG_IDLE, neg_out);
        m.set_strobe(1'b0, 1'b0);
        chk("neg kept", w, neg_out);
        m.set_sustain(1'b0);
        chk("sustain strobe", 32'h00000000, neg_out);
        m.set_strobe(1'b0, 1'b1);
        chk("sustain idle", 32'h00000000, neg_out);
        m.set_sustain(1'b1);
        chk("sustain off", NEG_IDLE, neg_out);
    endtask : t_neg

    task automatic t_reset();
        m.hold(2);
        i_resetn = 1'b0;
        m.hold(4);
        i_resetn = 1'b1;
        m.hold(6);
        m.set_strobe(1'b1, 1'b0);
        chk("reset pos store", POS_IDLE, pos_all);
        m.set_strobe(1'b0, 1'b0);
        chk("reset neg store", NEG_IDLE, neg_out);
        m.set_strobe(1'b1, 1'b1);
        m.set_strobe(1'b0, 1'b1);
        chk("reset rest", NEG_IDLE, neg_out);
    endtask : t_reset

    initial begin
        repeat (50000) @(posedge i_sys_clk);
        bad_count++;
        summarize();
    end

    initial begin
        bad_count = 0;
        cmp_count = 0;
        i_resetn = 1'b0;
        repeat (8) @(negedge i_sys_clk);
        i_resetn = 1'b1;
        m.hold(6);
        chk("reset pos", POS_IDLE, pos_all);
        chk("reset neg", NEG_IDLE, neg_out);
        t_groups();
        t_buffer();
        t_neg();
        t_reset();
        summarize();
    end
endmodule : tb
`default_nettype wire
